// >>> logic/hlg_core.sv
// Headlight general pins, sequence strobes, heartbeat and self-test control.
// Assumes host commands arrive as one-cycle pulses on the system clock;
// monitored status, flash ready and EEPROM straps are synchronised here; the flash test and auto-display straps are not.

// Behaviour
// - Three programmable PWM outputs on pins 00, 02 and 17.
// - Drive sequence-start strobe on pin 01 to the companion chip.
// - Keep a periodic heartbeat toggling on pin 15 during operation.
// - Sequence-aligned sampling trigger on pin 18, enabled by configuration.
// - Pins 06-08 and 26-31 are host-controlled general pins.
// - Non-periodic tests only outside operation; power-up set from flash.
// - Host-started non-periodic tests accepted only in standby.
// - Periodic tests run almost continually in display mode, self-managed.
// - Periodic checks: link, source clock, pixels/lines, video checksum.
// - Calibration read from optional 64 or 128 Kb EEPROM instead of flash.
// - Enter standby by itself after power-up unless the flash auto-display strap selects display; mirrors parked, no source.
module hlg_core (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire hlg_pkg::hlg_pwm_cfg_t i_pwm_cfg [hlg_pkg::PWM_CH],
    input wire logic i_pwm_load,
    input wire hlg_pkg::hlg_host_pin_t i_host_pin,
    input wire logic i_host_pin_load,
    input wire logic [hlg_pkg::HOST_PINS-1:0] i_host_pin_in,
    input wire logic i_cmd_display,
    input wire logic i_cmd_standby,
    input wire logic i_cmd_calib,
    input wire logic i_cmd_test,
    input wire logic [hlg_pkg::TEST_W-1:0] i_cmd_test_sel,
    input wire logic [hlg_pkg::TEST_W-1:0] i_flash_test_sel,
    input wire logic i_flash_auto_display,
    input wire logic i_flash_ready,
    input wire logic i_ee_present,
    input wire logic i_ee_128k,
    input wire logic i_smpl_en,
    input wire hlg_pkg::hlg_pstatus_t i_pstatus,
    input wire logic [hlg_pkg::TEST_W-1:0] i_nptest_fail,
    input wire logic i_err_clear,
    output logic [hlg_pkg::PWM_CH-1:0] o_lamp_pwm_out,
    output logic o_sequence_start_strobe,
    output logic o_heartbeat_pulse_out,
    output logic o_external_sample_trigger,
    output logic [hlg_pkg::HOST_PINS-1:0] o_host_pin_out,
    output logic [hlg_pkg::HOST_PINS-1:0] o_host_pin_oe,
    output logic [hlg_pkg::HOST_PINS-1:0] o_host_pin_in,
    output hlg_pkg::hlg_mode_t o_mode,
    output logic o_mirror_park,
    output logic o_test_busy,
    output logic o_cmd_rejected,
    output logic o_test_error,
    output logic [3:0] o_ptest_fail,
    output logic o_cal_from_eeprom,
    output logic [hlg_pkg::EE_ADDR_W-1:0] o_cal_addr_limit
);

    // ------------------------------------------------------------
    // Input synchronisers for asynchronous levels
    // ------------------------------------------------------------
    localparam int SW = 4 + hlg_pkg::HOST_PINS + 3;
    logic [SW-1:0] sync1_reg, sync2_reg;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {i_pstatus, i_host_pin_in, i_flash_ready,
                          i_ee_present, i_ee_128k};
            sync2_reg <= sync1_reg;
        end
    end
    hlg_pkg::hlg_pstatus_t pstat_s;
    logic flash_ready_s, ee_present_s, ee_128k_s;
    assign pstat_s = sync2_reg[SW-1 -: 4];
    assign o_host_pin_in = sync2_reg[3 +: hlg_pkg::HOST_PINS];
    assign flash_ready_s = sync2_reg[2];
    assign ee_present_s = sync2_reg[1];
    assign ee_128k_s = sync2_reg[0];

    // ------------------------------------------------------------
    // Mode and non-periodic test sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_INIT, ST_INIT_TEST, ST_STANDBY, ST_NP_TEST, ST_DISPLAY, ST_CALIB
    } hlg_state_t;
    hlg_state_t st_reg, st_next;
    logic [7:0] np_cnt_reg, np_cnt_next;
    logic [hlg_pkg::TEST_W-1:0] np_sel_reg, np_sel_next;
    logic auto_disp_reg, auto_disp_next;
    logic rej_next;
    logic err_reg, err_next;
    logic np_done;
    logic pfail_any;

    assign np_done = (np_cnt_reg == 8'(hlg_pkg::NPTEST_CYC - 1));

    always_comb begin
        st_next = st_reg;
        np_cnt_next = np_cnt_reg;
        np_sel_next = np_sel_reg;
        auto_disp_next = auto_disp_reg;
        rej_next = 1'b0;
        err_next = err_reg;
        case (st_reg)
            ST_INIT: begin
                if (flash_ready_s) begin
                    np_sel_next = i_flash_test_sel;
                    auto_disp_next = i_flash_auto_display;
                    np_cnt_next = '0;
                    st_next = ST_INIT_TEST;
                end
            end
            ST_INIT_TEST, ST_NP_TEST: begin
                np_cnt_next = np_cnt_reg + 8'h01;
                if (np_done) begin
                    if ((i_nptest_fail & np_sel_reg) != '0) begin
                        err_next = 1'b1;
                    end
                    if (st_reg == ST_INIT_TEST && auto_disp_reg) begin
                        st_next = ST_DISPLAY;
                    end else begin
                        st_next = ST_STANDBY;
                    end
                end
            end
            ST_STANDBY: begin
                if (i_cmd_test) begin
                    np_sel_next = i_cmd_test_sel;
                    np_cnt_next = '0;
                    st_next = ST_NP_TEST;
                end else if (i_cmd_display) begin
                    st_next = ST_DISPLAY;
                end else if (i_cmd_calib) begin
                    st_next = ST_CALIB;
                end
            end
            ST_DISPLAY, ST_CALIB: begin
                rej_next = i_cmd_test;
                if (i_cmd_standby) begin
                    st_next = ST_STANDBY;
                end else if (st_reg == ST_DISPLAY && i_cmd_calib) begin
                    st_next = ST_CALIB;
                end else if (st_reg == ST_CALIB && i_cmd_display) begin
                    st_next = ST_DISPLAY;
                end
            end
            default: st_next = ST_INIT;
        endcase
        if (st_reg == ST_INIT_TEST || st_reg == ST_NP_TEST) begin
            rej_next = i_cmd_test;
        end
        // Set wins over clear
        if (i_err_clear) begin
            err_next = 1'b0;
        end
        if (pfail_any || (np_done && (st_reg == ST_INIT_TEST ||
            st_reg == ST_NP_TEST) && (i_nptest_fail & np_sel_reg) != '0)) begin
            err_next = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg <= ST_INIT;
            np_cnt_reg <= '0;
            np_sel_reg <= '0;
            auto_disp_reg <= 1'b0;
            o_cmd_rejected <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            np_cnt_reg <= np_cnt_next;
            np_sel_reg <= np_sel_next;
            auto_disp_reg <= auto_disp_next;
            o_cmd_rejected <= rej_next;
            err_reg <= err_next;
        end
    end

    logic running;
    assign running = (st_reg == ST_DISPLAY) || (st_reg == ST_CALIB);
    assign o_test_error = err_reg;
    assign o_test_busy = (st_reg == ST_INIT_TEST) || (st_reg == ST_NP_TEST);
    assign o_mirror_park = !running;
    always_comb begin
        case (st_reg)
            ST_DISPLAY: o_mode = hlg_pkg::HLG_MODE_DISPLAY;
            ST_CALIB: o_mode = hlg_pkg::HLG_MODE_CALIB;
            default: o_mode = hlg_pkg::HLG_MODE_STANDBY;
        endcase
    end

    // ------------------------------------------------------------
    // Periodic test rotation during display
    // ------------------------------------------------------------
    logic [6:0] pt_cnt_reg, pt_cnt_next;
    hlg_pkg::hlg_ptest_t pt_sel_reg, pt_sel_next;
    logic [3:0] pfail_reg, pfail_next;
    logic pt_bad;

    always_comb begin
        case (pt_sel_reg)
            hlg_pkg::HLG_PT_LINK: pt_bad = !pstat_s.link_ok;
            hlg_pkg::HLG_PT_SRC_CLK: pt_bad = !pstat_s.src_clk_ok;
            hlg_pkg::HLG_PT_SRC_ACTIVE: pt_bad = !pstat_s.src_active_ok;
            default: pt_bad = !pstat_s.checksum_ok;
        endcase
        pt_cnt_next = pt_cnt_reg;
        pt_sel_next = pt_sel_reg;
        pfail_next = pfail_reg;
        pfail_any = 1'b0;
        if (st_reg == ST_DISPLAY) begin
            if (pt_cnt_reg == 7'(hlg_pkg::PTEST_SLOT_CYC - 1)) begin
                pt_cnt_next = '0;
                pt_sel_next = hlg_pkg::hlg_ptest_t'(pt_sel_reg + 2'd1);
                if (pt_bad) begin
                    pfail_next[pt_sel_reg] = 1'b1;
                    pfail_any = 1'b1;
                end
            end else begin
                pt_cnt_next = pt_cnt_reg + 7'd1;
            end
        end
        if (i_err_clear && !pfail_any) begin
            pfail_next = '0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pt_cnt_reg <= '0;
            pt_sel_reg <= hlg_pkg::HLG_PT_LINK;
            pfail_reg <= '0;
        end else begin
            pt_cnt_reg <= pt_cnt_next;
            pt_sel_reg <= pt_sel_next;
            pfail_reg <= pfail_next;
        end
    end
    assign o_ptest_fail = pfail_reg;

    // ------------------------------------------------------------
    // Sequence timing: start strobe, sample trigger, heartbeat
    // ------------------------------------------------------------
    logic [9:0] seq_cnt_reg, seq_cnt_next;
    logic strobe_reg, strobe_next, smpl_reg, smpl_next;
    logic [15:0] hb_cnt_reg, hb_cnt_next;
    logic hb_reg, hb_next;

    always_comb begin
        seq_cnt_next = seq_cnt_reg;
        strobe_next = 1'b0;
        smpl_next = 1'b0;
        if (running) begin
            if (seq_cnt_reg == 10'(hlg_pkg::SEQ_PERIOD_CYC - 1)) begin
                seq_cnt_next = '0;
            end else begin
                seq_cnt_next = seq_cnt_reg + 10'd1;
            end
            strobe_next = (seq_cnt_reg == '0);
            smpl_next = i_smpl_en &&
                (seq_cnt_reg == 10'(hlg_pkg::SMPL_OFFSET_CYC));
        end else begin
            seq_cnt_next = '0;
        end
        hb_next = hb_reg;
        if (hb_cnt_reg == 16'(hlg_pkg::HB_HALF_CYC - 1)) begin
            hb_cnt_next = hlg_pkg::HB_HALF_RST;
            hb_next = !hb_reg;
        end else begin
            hb_cnt_next = hb_cnt_reg + 16'd1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            seq_cnt_reg <= '0;
            strobe_reg <= 1'b0;
            smpl_reg <= 1'b0;
            hb_cnt_reg <= hlg_pkg::HB_HALF_RST;
            hb_reg <= 1'b0;
        end else begin
            seq_cnt_reg <= seq_cnt_next;
            strobe_reg <= strobe_next;
            smpl_reg <= smpl_next;
            hb_cnt_reg <= hb_cnt_next;
            hb_reg <= hb_next;
        end
    end
    assign o_sequence_start_strobe = strobe_reg;
    assign o_external_sample_trigger = smpl_reg;
    assign o_heartbeat_pulse_out = hb_reg;

    // ------------------------------------------------------------
    // PWM channels
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < hlg_pkg::PWM_CH; g++) begin : g_pwm
            hlg_pkg::hlg_pwm_cfg_t cfg_reg, cfg_next;
            logic [hlg_pkg::PWM_W-1:0] cnt_reg, cnt_next;
            logic out_reg, out_next;
            always_comb begin
                cfg_next = i_pwm_load ? i_pwm_cfg[g] : cfg_reg;
                if (cnt_reg >= cfg_reg.period) begin
                    cnt_next = '0;
                end else begin
                    cnt_next = cnt_reg + 16'h0001;
                end
                out_next = (cnt_reg < cfg_reg.duty);
            end
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    cfg_reg <= {hlg_pkg::PWM_PERIOD_RST, hlg_pkg::PWM_DUTY_RST};
                    cnt_reg <= '0;
                    out_reg <= 1'b0;
                end else begin
                    cfg_reg <= cfg_next;
                    cnt_reg <= cnt_next;
                    out_reg <= out_next;
                end
            end
            assign o_lamp_pwm_out[g] = out_reg;
        end
    endgenerate

    // ------------------------------------------------------------
    // Host pins and calibration source
    // ------------------------------------------------------------
    hlg_pkg::hlg_host_pin_t hp_reg, hp_next;
    logic cal_ee_reg, cal_ee_next;
    always_comb begin
        hp_next = i_host_pin_load ? i_host_pin : hp_reg;
        cal_ee_next = ee_present_s;
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hp_reg <= '0;
            cal_ee_reg <= 1'b0;
        end else begin
            hp_reg <= hp_next;
            cal_ee_reg <= cal_ee_next;
        end
    end
    assign o_host_pin_out = hp_reg.out;
    assign o_host_pin_oe = hp_reg.oe;
    assign o_cal_from_eeprom = cal_ee_reg;
    // 64 Kb is 8 KB, 128 Kb is 16 KB
    assign o_cal_addr_limit = ee_128k_s ? 14'h3FFF : 14'h1FFF;

endmodule

// >>> logic/hlg_pkg.sv
// Shared constants and carrier types for the headlight pin and self-test block.
// Assumes a single 10 MHz clock and an active-high asynchronous reset.
package hlg_pkg;

    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int PWM_W = 16;
    localparam int PWM_CH = 3;
    localparam int HOST_PINS = 9;
    localparam int TEST_W = 8;
    localparam int CLK_HZ = 10000000;
    localparam int HB_HALF_US = 500;
    localparam int HB_HALF_CYC = (HB_HALF_US * (CLK_HZ / 1000000));
    localparam int SEQ_PERIOD_CYC = 1000;
    localparam int SMPL_OFFSET_CYC = 100;
    localparam int PTEST_SLOT_CYC = 64;
    localparam int NPTEST_CYC = 16;
    localparam int EE_ADDR_W = 14;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PWM_W-1:0] PWM_PERIOD_RST = 16'h00FF;
    localparam logic [PWM_W-1:0] PWM_DUTY_RST = 16'h0000;
    localparam logic [15:0] HB_HALF_RST = 16'h0000;

    // ------------------------------------------------------------
    // Modes and periodic test kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HLG_MODE_STANDBY,
        HLG_MODE_DISPLAY,
        HLG_MODE_CALIB
    } hlg_mode_t;

    typedef enum logic [1:0] {
        HLG_PT_LINK,
        HLG_PT_SRC_CLK,
        HLG_PT_SRC_ACTIVE,
        HLG_PT_CHECKSUM
    } hlg_ptest_t;

    typedef struct packed {
        logic [PWM_W-1:0] period;
        logic [PWM_W-1:0] duty;
    } hlg_pwm_cfg_t;

    typedef struct packed {
        logic [HOST_PINS-1:0] oe;
        logic [HOST_PINS-1:0] out;
    } hlg_host_pin_t;

    typedef struct packed {
        logic link_ok;
        logic src_clk_ok;
        logic src_active_ok;
        logic checksum_ok;
    } hlg_pstatus_t;

endpackage

// >>> bench/hlg_props.sv
// Checker for the headlight pin and self-test block.
// Sees only hlg_core ports; bound to every instance below.
module hlg_props (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cmd_test,
    input wire logic i_smpl_en,
    input wire logic i_ee_128k,
    input wire logic i_err_clear,
    input wire logic i_host_pin_load,
    input wire hlg_pkg::hlg_host_pin_t i_host_pin,
    input wire logic o_sequence_start_strobe,
    input wire logic o_heartbeat_pulse_out,
    input wire logic o_external_sample_trigger,
    input wire logic [hlg_pkg::HOST_PINS-1:0] o_host_pin_out,
    input wire hlg_pkg::hlg_mode_t o_mode,
    input wire logic o_mirror_park,
    input wire logic o_test_busy,
    input wire logic o_cmd_rejected,
    input wire logic o_test_error,
    input wire logic [hlg_pkg::EE_ADDR_W-1:0] o_cal_addr_limit
);
    localparam int SM_LO = 99;
    localparam int SM_HI = 101;
    logic hb_last_reg, hb_seen_reg, hb_seen_next;
    logic seq_seen_reg, seq_seen_next;
    logic [12:0] hb_gap_reg, hb_gap_next;
    logic [10:0] seq_gap_reg, seq_gap_next;
    wire hb_tog = o_heartbeat_pulse_out != hb_last_reg;
    wire idle = o_mode == hlg_pkg::HLG_MODE_STANDBY;
    // ----------------------------------------
    // Gap counters since the last edge or strobe
    // ----------------------------------------
    always_comb begin
        hb_seen_next = hb_seen_reg | hb_tog;
        hb_gap_next = hb_tog ? 13'h0001 : hb_gap_reg + 13'h0001;
        seq_seen_next = !idle & (seq_seen_reg | o_sequence_start_strobe);
        seq_gap_next = o_sequence_start_strobe ? 11'h001 : seq_gap_reg + 11'h001;
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hb_last_reg <= 1'b0;
            hb_seen_reg <= 1'b0;
            seq_seen_reg <= 1'b0;
            hb_gap_reg <= 13'h0000;
            seq_gap_reg <= 11'h000;
        end else begin
            hb_last_reg <= o_heartbeat_pulse_out;
            hb_seen_reg <= hb_seen_next;
            seq_seen_reg <= seq_seen_next;
            hb_gap_reg <= hb_gap_next;
            seq_gap_reg <= seq_gap_next;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    property p_hb;
        hb_seen_reg |-> (hb_tog ? hb_gap_reg == hlg_pkg::HB_HALF_CYC
                                : hb_gap_reg < hlg_pkg::HB_HALF_CYC);
    endproperty
    a_hb: assert property (p_hb) else $error("heartbeat gap wrong");
    property p_seq;
        seq_seen_reg && !idle |-> (o_sequence_start_strobe
            ? seq_gap_reg == hlg_pkg::SEQ_PERIOD_CYC
            : seq_gap_reg < hlg_pkg::SEQ_PERIOD_CYC);
    endproperty
    a_seq: assert property (p_seq) else $error("strobe gap wrong");
    property p_smpl;
        o_sequence_start_strobe && i_smpl_en |->
            ##[SM_LO:SM_HI] o_external_sample_trigger;
    endproperty
    a_smpl: assert property (p_smpl) else $error("no trigger");
    property p_nosmpl;
        !i_smpl_en && !$past(i_smpl_en) |-> !o_external_sample_trigger;
    endproperty
    a_nosmpl: assert property (p_nosmpl) else $error("stray pulse");
    property p_rej;
        i_cmd_test && o_mode == hlg_pkg::HLG_MODE_DISPLAY |=> o_cmd_rejected;
    endproperty
    a_rej: assert property (p_rej) else $error("test not refused");
    property p_busy;
        i_cmd_test && idle && !o_test_busy |=>
            o_test_busy [*8] ##8 o_test_busy ##1 !o_test_busy;
    endproperty
    a_busy: assert property (p_busy) else $error("bad test length");
    property p_park;
        o_mirror_park == idle;
    endproperty
    a_park: assert property (p_park) else $error("park wrong");
    property p_err;
        o_test_error && !i_err_clear |=> o_test_error;
    endproperty
    a_err: assert property (p_err) else $error("error flag lost");
    property p_lim;
        i_ee_128k [*4] |-> o_cal_addr_limit == 14'h3FFF;
    endproperty
    a_lim: assert property (p_lim) else $error("limit wrong");
    property p_pin;
        i_host_pin_load |=> o_host_pin_out == $past(i_host_pin.out);
    endproperty
    a_pin: assert property (p_pin) else $error("host pin wrong");
    c_test: cover property (i_cmd_test && idle ##1 o_test_busy);
    c_rej: cover property (o_cmd_rejected);
    c_smpl: cover property (o_external_sample_trigger);
endmodule

bind hlg_core hlg_props u_props (.i_clk, .i_rst, .i_cmd_test, .i_smpl_en,
    .i_ee_128k, .i_err_clear, .i_host_pin_load, .i_host_pin,
    .o_sequence_start_strobe, .o_heartbeat_pulse_out,
    .o_external_sample_trigger, .o_host_pin_out, .o_mode, .o_mirror_park,
    .o_test_busy, .o_cmd_rejected, .o_test_error, .o_cal_addr_limit);

// >>> bench/hlg_companion.sv
// Companion model: watches the heartbeat, counts beats and sample starts.
// Shares the bench clock; sees only block outputs.
module hlg_companion (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_heartbeat,
    input wire logic i_trigger,
    output logic o_fault,
    output int o_beats,
    output int o_samples
);
    int quiet;
    logic last;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            quiet <= 0;
            last <= 1'b0;
            o_fault <= 1'b0;
            o_beats <= 0;
            o_samples <= 0;
        end else begin
            last <= i_heartbeat;
            quiet <= (i_heartbeat != last) ? 0 : quiet + 1;
            o_beats <= o_beats + int'(i_heartbeat != last);
            o_samples <= o_samples + int'(i_trigger);
            if (quiet > hlg_pkg::HB_HALF_CYC + 8) o_fault <= 1'b1;
        end
    end
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the headlight pin and self-test block.
// Inputs change on the falling edge; a companion model watches outputs.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] cmds;
    logic i_pwm_load, i_host_pin_load, i_err_clear, i_flash_ready;
    logic i_ee_present, i_ee_128k, i_smpl_en, i_flash_auto_display;
    logic [hlg_pkg::HOST_PINS-1:0] i_host_pin_in;
    logic [hlg_pkg::TEST_W-1:0] i_cmd_test_sel, i_flash_test_sel;
    logic [hlg_pkg::TEST_W-1:0] i_nptest_fail;
    hlg_pkg::hlg_pwm_cfg_t i_pwm_cfg [hlg_pkg::PWM_CH];
    hlg_pkg::hlg_host_pin_t i_host_pin;
    hlg_pkg::hlg_pstatus_t i_pstatus;
    logic [hlg_pkg::PWM_CH-1:0] o_lamp_pwm_out;
    logic o_sequence_start_strobe, o_heartbeat_pulse_out;
    logic o_external_sample_trigger, o_mirror_park, o_test_busy;
    logic o_cmd_rejected, o_test_error, o_cal_from_eeprom, peer_fault;
    logic [hlg_pkg::HOST_PINS-1:0] o_host_pin_out, o_host_pin_oe;
    logic [hlg_pkg::HOST_PINS-1:0] o_host_pin_in;
    hlg_pkg::hlg_mode_t o_mode;
    logic [3:0] o_ptest_fail;
    logic [hlg_pkg::EE_ADDR_W-1:0] o_cal_addr_limit;
    wire i_cmd_display = cmds[0];
    wire i_cmd_standby = cmds[1];
    wire i_cmd_calib = cmds[2];
    wire i_cmd_test = cmds[3];
    logic [1:0] notes [$];
    logic busy_q = 1'b0;
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int beats, samples, n, t, hi;

    hlg_core dut (.i_clk, .i_rst, .i_pwm_cfg, .i_pwm_load, .i_host_pin,
        .i_host_pin_load, .i_host_pin_in, .i_cmd_display, .i_cmd_standby,
        .i_cmd_calib, .i_cmd_test, .i_cmd_test_sel, .i_flash_test_sel,
        .i_flash_auto_display, .i_flash_ready, .i_ee_present, .i_ee_128k,
        .i_smpl_en, .i_pstatus, .i_nptest_fail, .i_err_clear,
        .o_lamp_pwm_out, .o_sequence_start_strobe, .o_heartbeat_pulse_out,
        .o_external_sample_trigger, .o_host_pin_out, .o_host_pin_oe,
        .o_host_pin_in, .o_mode, .o_mirror_park, .o_test_busy,
        .o_cmd_rejected, .o_test_error, .o_ptest_fail, .o_cal_from_eeprom,
        .o_cal_addr_limit);
    hlg_companion peer (.i_clk, .i_rst, .i_heartbeat(o_heartbeat_pulse_out),
        .i_trigger(o_external_sample_trigger), .o_fault(peer_fault),
        .o_beats(beats), .o_samples(samples));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge i_clk);
    endtask
    task automatic cmd(input int k);
        cmds = 4'h1 << k;
        tick(1);
        cmds = 4'h0;
    endtask
    task automatic clr();
        i_err_clear = 1'b1;
        tick(1);
        i_err_clear = 1'b0;
    endtask
    task automatic load_pins();
        i_host_pin_load = 1'b1;
        tick(1);
        i_host_pin_load = 1'b0;
        chk("pin_out", i_host_pin.out, o_host_pin_out);
        chk("pin_oe", i_host_pin.oe, o_host_pin_oe);
    endtask
    task automatic idle();
        int k = 0;
        while (o_test_busy !== 1'b1 && k < 40) begin
            tick(1);
            k++;
        end
        while (o_test_busy !== 1'b0 && k < 80) begin
            tick(1);
            k++;
        end
        tick(1);
        chk("busy", 0, o_test_busy);
    endtask
    task automatic seq();
        n = 0;
        while (o_sequence_start_strobe !== 1'b1 && n < 1100) begin
            tick(1);
            n++;
        end
        n = 0;
        t = 0;
        do begin
            tick(1);
            n++;
            if (o_external_sample_trigger === 1'b1) t = n;
        end while (o_sequence_start_strobe !== 1'b1 && n < 1100);
    endtask
    task automatic take(input logic [1:0] got);
        if (notes.size() == 0) chk("note", 2'b11, got);
        else chk("result", notes.pop_front(), got);
    endtask
    task automatic conclude();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial forever #50 i_clk = ~i_clk;
    always @(negedge i_clk) begin
        if (busy_q && o_test_busy === 1'b0) take({1'b0, o_test_error});
        if (o_cmd_rejected === 1'b1) take(2'b10);
        busy_q <= o_test_busy;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            conclude();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(16975));
        cmds = 4'h0;
        {i_pwm_load, i_host_pin_load, i_err_clear} = 3'h0;
        {i_ee_present, i_ee_128k, i_flash_auto_display} = 3'b110;
        {i_flash_ready, i_smpl_en} = 2'b11;
        i_host_pin = '0;
        i_host_pin_in = '0;
        i_cmd_test_sel = '0;
        i_flash_test_sel = 8'h0F;
        i_nptest_fail = 8'h30;
        i_pstatus = 4'hF;
        foreach (i_pwm_cfg[c]) i_pwm_cfg[c] = '0;
        tick(2);
        chk("mode", hlg_pkg::HLG_MODE_STANDBY, o_mode);
        chk("park", 1, o_mirror_park);
        notes.push_back(2'b00);
        i_rst = 1'b0;
        idle();
        chk("mode", hlg_pkg::HLG_MODE_STANDBY, o_mode);
        chk("cal_src", 1, o_cal_from_eeprom);
        chk("limit", 14'h3FFF, o_cal_addr_limit);
        i_ee_128k = 1'b0;
        tick(5);
        chk("limit", 14'h1FFF, o_cal_addr_limit);
        for (int k = 0; k < 3; k++) begin
            i_cmd_test_sel = 8'($urandom_range(1, 255));
            i_nptest_fail = ~i_cmd_test_sel;
            if (k == 1) i_nptest_fail = i_cmd_test_sel & (~i_cmd_test_sel + 1);
            notes.push_back({1'b0, k > 0});
            cmd(3);
            idle();
        end
        clr();
        chk("error", 0, o_test_error);
        i_host_pin = hlg_pkg::hlg_host_pin_t'(18'($urandom));
        i_host_pin_in = 9'($urandom);
        load_pins();
        tick(3);
        chk("pin_in", i_host_pin_in, o_host_pin_in);
        i_host_pin = {9'h1FF, 9'h000};
        load_pins();
        foreach (i_pwm_cfg[c]) begin
            i_pwm_cfg[c].period = 16'($urandom_range(8, 40));
            i_pwm_cfg[c].duty = 16'($urandom_range(0, 41));
        end
        i_pwm_load = 1'b1;
        tick(1);
        i_pwm_load = 1'b0;
        tick(300);
        foreach (i_pwm_cfg[c]) begin
            hi = 0;
            repeat (i_pwm_cfg[c].period + 1) begin
                tick(1);
                hi += o_lamp_pwm_out[c];
            end
            n = i_pwm_cfg[c].period + 1;
            if (i_pwm_cfg[c].duty < n) n = i_pwm_cfg[c].duty;
            chk("pwm", n, hi);
        end
        cmd(0);
        chk("mode", hlg_pkg::HLG_MODE_DISPLAY, o_mode);
        chk("park", 0, o_mirror_park);
        notes.push_back(2'b10);
        cmd(3);
        for (int e = 1; e >= 0; e--) begin
            i_smpl_en = e[0];
            seq();
            chk("seq_gap", hlg_pkg::SEQ_PERIOD_CYC, n);
            chk("smpl_at", e * hlg_pkg::SMPL_OFFSET_CYC, t);
        end
        for (int i = 0; i < 4; i++) begin
            i_pstatus = 4'hF ^ (4'h8 >> i);
            tick(300);
            chk("ptest", 4'h1 << i, o_ptest_fail);
            chk("error", 1, o_test_error);
            i_pstatus = 4'hF;
            tick(80);
            clr();
            chk("ptest", 0, o_ptest_fail);
        end
        cmd(1);
        chk("mode", hlg_pkg::HLG_MODE_STANDBY, o_mode);
        cmd(2);
        chk("mode", hlg_pkg::HLG_MODE_CALIB, o_mode);
        chk("park", 0, o_mirror_park);
        cmd(1);
        tick(2 * hlg_pkg::HB_HALF_CYC);
        chk("hb_fault", 0, peer_fault);
        chk("beats", 1, beats >= 2);
        chk("samples", 1, samples > 0);
        chk("notes_left", 0, notes.size());
        conclude();
    end
endmodule
